// [design/mpf_regs.vh]
// Register map, field positions, reset values and timing counts of the
// priority pause receive gate and fault handling block.
// Assumes inclusion by bare name from every design file of the block.
// Summary of operation
// (R01) With its priority 7 enable and the global receive priority pause enable both set, a received priority pause frame with valid quanta for priority 7 is processed.
// (R02) With the priority 7 enable cleared, the priority 7 pause output stays low whatever frames arrive.
// (R03) Enable bits 6 to 0 gate the pause outputs of priorities 6 to 0 in the same way.
// (R04) The eight receive priority enables exist only when priority pause support is built in, resetting to 1 then and to 0 otherwise.
// (R05) Bit 29 of the reconciliation word is read-only and reads 1 while remote fault sequences are received.
// (R06) Bit 28 of the reconciliation word is read-only and reads 1 while local fault sequences are received.
// (R07) With fault inhibit (bit 27, reset 0) clear, remote fault sequences are sent while local faults are received.
// (R08) With fault inhibit clear, idles replace client data while remote faults are received.
// (R09) With fault inhibit set, client data is always sent regardless of received faults.
// (R10) Global receive priority pause enable at bit 25 lets frames drive the enabled outputs; when clear, frames are ignored and passed to the client.
// (R11) Reserved bits of the reconciliation word read as zero and writes to them do nothing.
`ifndef MPF_REGS_VH
`define MPF_REGS_VH

`define MPF_ADDR_W             8
`define MPF_ADDR_FLOW_CTRL     8'h00
`define MPF_ADDR_RS_CFG        8'h04
`define MPF_ADDR_INT_STATUS    8'h08
`define MPF_ADDR_INT_CLEAR     8'h0C
`define MPF_ADDR_INT_ENABLE    8'h10

`define MPF_FC_TX_PAUSE_BIT    30
`define MPF_FC_RX_PAUSE_BIT    29
`define MPF_FC_TX_PFC_BIT      26
`define MPF_FC_RX_PFC_BIT      25
`define MPF_FC_TX_AUTO_XON_BIT 20
`define MPF_FC_TX_PRIO_LSB     8
`define MPF_FC_RX_PRIO_LSB     0
`define MPF_FC_RESET_PFC       32'h6010FFFF
`define MPF_FC_RESET_NO_PFC    32'h60000000
`define MPF_FC_MASK_PFC        32'h6610FFFF
`define MPF_FC_MASK_NO_PFC     32'h60000000

`define MPF_RS_REMOTE_BIT      29
`define MPF_RS_LOCAL_BIT       28
`define MPF_RS_INHIBIT_BIT     27

`define MPF_INT_LOCAL_BIT      0
`define MPF_INT_REMOTE_BIT     1
`define MPF_INT_PFC_BIT        2
`define MPF_INT_W              3

`define MPF_CLK_PERIOD_PS      8000
`define MPF_QUANTA_PS          51200
`define MPF_QUANTA_CYCLES      ((`MPF_QUANTA_PS + `MPF_CLK_PERIOD_PS - 1) / `MPF_CLK_PERIOD_PS)

`define MPF_FAULT_SEQ_COUNT    4
`define MPF_FAULT_CLEAR_COLS   128

`define MPF_CTL_SEQUENCE       8'h9C
`define MPF_CTL_IDLE           8'h07
`define MPF_SEQ_LOCAL          8'h01
`define MPF_SEQ_REMOTE         8'h02

`endif

// [design/mpf_pfc_rx.v]
// Per-priority receive pause timers and output gating.
// Assumes the frame parser on the same clock gives a one-cycle frame pulse
// with a vector of priorities that carry valid quanta.
`timescale 1ns/100ps
`include "mpf_regs.vh"
module mpf_pfc_rx
#(
   parameter NPRIO         = 8,
   parameter QW            = 16,
   parameter QUANTA_CYCLES = `MPF_QUANTA_CYCLES
)
(
   input  wire                  clk,         // Core clock.
   input  wire                  nrst,        // Asynchronous reset, active low.
   input  wire                  frame_valid, // One-cycle pulse per pause frame.
   input  wire [NPRIO-1:0]      prio_vec,    // Priorities with valid quanta.
   input  wire [NPRIO*QW-1:0]   quanta,      // Quanta per priority.
   input  wire [NPRIO-1:0]      prio_en,     // Per-priority enables.
   input  wire                  global_en,   // Global receive enable.
   output reg  [NPRIO-1:0]      pause_out,   // Pause level per priority.
   output reg                   taken,       // Pulse: frame processed.
   output reg                   passed       // Pulse: frame passed to client.
);
   reg [QW-1:0] cnt [0:NPRIO-1];
   reg [7:0]    div;
   reg          tick;
   integer      i;

   // Quanta tick is a one-cycle enable every QUANTA_CYCLES cycles, 512 bit times rounded up to whole cycles (7 by default).
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div  <= 8'h00;
         tick <= 1'b0;
      end
      else if (div == QUANTA_CYCLES[7:0] - 8'h01)
      begin
         div  <= 8'h00;
         tick <= 1'b1;
      end
      else
      begin
         div  <= div + 8'h01;
         tick <= 1'b0;
      end
   end

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (i = 0; i < NPRIO; i = i + 1)
            cnt[i] <= {QW{1'b0}};
         pause_out <= {NPRIO{1'b0}};
         taken     <= 1'b0;
         passed    <= 1'b0;
      end
      else
      begin
         taken  <= frame_valid & global_en; // R10
         passed <= frame_valid & ~global_en; // R10
         for (i = 0; i < NPRIO; i = i + 1)
         begin
            if (!prio_en[i] || !global_en)
            begin
               cnt[i]       <= {QW{1'b0}}; // R02 R03
               pause_out[i] <= 1'b0; // R02 R03
            end
            else if (frame_valid && prio_vec[i])
            begin
               cnt[i]       <= quanta[i*QW +: QW]; // R01 R03
               pause_out[i] <= |quanta[i*QW +: QW]; // R01 R03
            end
            else
            begin
               if (tick && cnt[i] != {QW{1'b0}})
                  cnt[i] <= cnt[i] - {{(QW-1){1'b0}}, 1'b1};
               pause_out[i] <= (cnt[i] > {{(QW-1){1'b0}}, 1'b1}) ||
                               (cnt[i] == {{(QW-1){1'b0}}, 1'b1} && !tick);
            end
         end
      end
   end
endmodule // mpf_pfc_rx

// [design/mpf_rs_fault.v]
// Fault sequence detection on the receive side and transmit replacement.
// Assumes 64-bit XGMII style data with 8 control bits, two columns per word,
// on the core clock.
`timescale 1ns/100ps
`include "mpf_regs.vh"
module mpf_rs_fault
#(
   parameter SEQ_COUNT  = `MPF_FAULT_SEQ_COUNT,
   parameter CLEAR_COLS = `MPF_FAULT_CLEAR_COLS
)
(
   input  wire        clk,          // Core clock.
   input  wire        nrst,         // Asynchronous reset, active low.
   input  wire [63:0] rxd,          // Receive data from the PCS.
   input  wire [7:0]  rxc,          // Receive control from the PCS.
   input  wire [63:0] txd_in,       // Transmit data from the MAC.
   input  wire [7:0]  txc_in,       // Transmit control from the MAC.
   input  wire        inhibit,      // Fault inhibit.
   output reg  [63:0] txd_out,      // Transmit data to the PCS.
   output reg  [7:0]  txc_out,      // Transmit control to the PCS.
   output reg         local_fault,  // Local faults being received.
   output reg         remote_fault  // Remote faults being received.
);
   reg [1:0] last_kind;
   reg [3:0] seq_cnt;
   reg [7:0] col_cnt;
   wire [1:0] kind_lo;
   wire [1:0] kind_hi;
   wire [1:0] kind;

   // Returns 01 for a local fault column, 10 for remote, 00 otherwise.
   function [1:0] seq_kind;
      input [31:0] d;
      input [3:0]  c;
      begin
         seq_kind = 2'b00;
         if (c == 4'h1 && d[7:0] == `MPF_CTL_SEQUENCE && d[23:8] == 16'h0000)
         begin
            if (d[31:24] == `MPF_SEQ_LOCAL)
               seq_kind = 2'b01;
            else if (d[31:24] == `MPF_SEQ_REMOTE)
               seq_kind = 2'b10;
         end
      end
   endfunction

   assign kind_lo = seq_kind(rxd[31:0], rxc[3:0]);
   assign kind_hi = seq_kind(rxd[63:32], rxc[7:4]);
   assign kind    = (kind_hi != 2'b00) ? kind_hi : kind_lo;

   // Fault is declared after a run of same-kind sequences and cleared after
   // a long stretch of words without one.
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         last_kind    <= 2'b00;
         seq_cnt      <= 4'h0;
         col_cnt      <= 8'h00;
         local_fault  <= 1'b0;
         remote_fault <= 1'b0;
      end
      else if (kind != 2'b00)
      begin
         col_cnt <= 8'h00;
         if (kind != last_kind)
         begin
            last_kind <= kind;
            seq_cnt   <= 4'h1;
         end
         else if (seq_cnt < SEQ_COUNT[3:0])
            seq_cnt <= seq_cnt + 4'h1;
         if (kind == last_kind && seq_cnt >= SEQ_COUNT[3:0] - 4'h1)
         begin
            local_fault  <= kind[0]; // R06
            remote_fault <= kind[1]; // R05
         end
      end
      else if (col_cnt >= CLEAR_COLS[7:0] / 8'h02 - 8'h01)
      begin
         col_cnt      <= 8'h00;
         seq_cnt      <= 4'h0;
         last_kind    <= 2'b00;
         local_fault  <= 1'b0; // R06
         remote_fault <= 1'b0; // R05
      end
      else
         col_cnt <= col_cnt + 8'h01;
   end

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txd_out <= {8{`MPF_CTL_IDLE}};
         txc_out <= 8'hFF;
      end
      else if (!inhibit && local_fault)
      begin
         txd_out <= {2{`MPF_SEQ_REMOTE, 16'h0000, `MPF_CTL_SEQUENCE}}; // R07
         txc_out <= 8'h11; // R07
      end
      else if (!inhibit && remote_fault)
      begin
         txd_out <= {8{`MPF_CTL_IDLE}}; // R08
         txc_out <= 8'hFF; // R08
      end
      else
      begin
         txd_out <= txd_in; // R09
         txc_out <= txc_in; // R09
      end
   end
endmodule // mpf_rs_fault

// [design/mpf_top.v]
// Top of the priority pause receive gate and fault handling block, with an
// APB register slave and a level interrupt.
// Assumes every input is produced on CLOCK by logic of the same domain.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/100ps
`include "mpf_regs.vh"
module mpf_top
#(
   parameter HAS_PFC       = 1,
   parameter NPRIO         = 8,
   parameter QW            = 16,
   parameter QUANTA_CYCLES = `MPF_QUANTA_CYCLES
)
(
   input  wire                 CLOCK,              // Core clock, 125 MHz.
   input  wire                 NRST,               // Asynchronous reset.
   input  wire                 PSEL,               // APB select.
   input  wire                 PENABLE,            // APB access phase.
   input  wire                 PWRITE,             // APB direction.
   input  wire [7:0]           PADDR,              // APB byte address.
   input  wire [31:0]          PWDATA,             // APB write data.
   input  wire [3:0]           PSTRB,              // APB byte strobes.
   output reg  [31:0]          PRDATA,             // APB read data.
   output reg                  PREADY,             // APB ready.
   output reg                  PSLVERR,            // APB error.
   input  wire                 RX_PFC_VALID,       // Pause frame pulse.
   input  wire [NPRIO-1:0]     RX_PFC_PRIO,        // Priorities with quanta.
   input  wire [NPRIO*QW-1:0]  RX_PFC_QUANTA,      // Quanta per priority.
   output reg                  RX_PFC_PASS,        // Frame passed to client.
   output wire                 RX_PRIO7_PAUSE_OUT, // Priority 7 pause.
   output wire                 RX_PRIO6_PAUSE_OUT, // Priority 6 pause.
   output wire                 RX_PRIO5_PAUSE_OUT, // Priority 5 pause.
   output wire                 RX_PRIO4_PAUSE_OUT, // Priority 4 pause.
   output wire                 RX_PRIO3_PAUSE_OUT, // Priority 3 pause.
   output wire                 RX_PRIO2_PAUSE_OUT, // Priority 2 pause.
   output wire                 RX_PRIO1_PAUSE_OUT, // Priority 1 pause.
   output wire                 RX_PRIO0_PAUSE_OUT, // Priority 0 pause.
   input  wire [63:0]          RXD,                // Receive data from PCS.
   input  wire [7:0]           RXC,                // Receive control.
   input  wire [63:0]          TXD_IN,             // Transmit data from MAC.
   input  wire [7:0]           TXC_IN,             // Transmit control.
   output wire [63:0]          TXD_OUT,            // Transmit data to PCS.
   output wire [7:0]           TXC_OUT,            // Transmit control to PCS.
   output reg  [31:0]          FLOW_CTRL_CFG,      // Flow control word.
   output reg                  IRQ                 // Level interrupt.
);
   localparam [31:0] FC_RESET = (HAS_PFC != 0) ? `MPF_FC_RESET_PFC
                                               : `MPF_FC_RESET_NO_PFC;
   localparam [31:0] FC_MASK  = (HAS_PFC != 0) ? `MPF_FC_MASK_PFC
                                               : `MPF_FC_MASK_NO_PFC;
   localparam [31:0] RS_MASK  = 32'h1 << `MPF_RS_INHIBIT_BIT;

   reg                    inhibit;
   reg [`MPF_INT_W-1:0]   int_status;
   reg [`MPF_INT_W-1:0]   int_enable;
   reg                    local_d;
   reg                    remote_d;
   reg [31:0]             next_prdata;
   reg                    next_slverr;
   reg [`MPF_INT_W-1:0]   next_status;
   wire                   local_fault;
   wire                   remote_fault;
   wire [NPRIO-1:0]       pause_out;
   wire                   pfc_taken;
   wire                   pfc_passed;
   wire                   access;
   wire                   wr;
   wire                   hit_fc;
   wire                   hit_rs;
   wire                   hit_st;
   wire                   hit_clr;
   wire                   hit_en;
   wire [31:0]            rs_word;
   wire [`MPF_INT_W-1:0]  events;

   // Merges write data into a register under the byte strobes and a mask of
   // bits that exist.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      input [31:0] mask;
      reg   [31:0] m;
      begin
         m     = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
         merge = (old & ~m) | (data & m);
      end
   endfunction

   assign access  = PSEL & PENABLE & ~PREADY;
   // A write lands at the edge that completes the transfer, with PREADY high.
   assign wr      = PSEL & PENABLE & PREADY & PWRITE;
   assign hit_fc  = (PADDR == `MPF_ADDR_FLOW_CTRL);
   assign hit_rs  = (PADDR == `MPF_ADDR_RS_CFG);
   assign hit_st  = (PADDR == `MPF_ADDR_INT_STATUS);
   assign hit_clr = (PADDR == `MPF_ADDR_INT_CLEAR);
   assign hit_en  = (PADDR == `MPF_ADDR_INT_ENABLE);

   // Reserved bits of the reconciliation word are held at zero.
   assign rs_word = ({31'h0, remote_fault} << `MPF_RS_REMOTE_BIT) | // R05 R11
                    ({31'h0, local_fault} << `MPF_RS_LOCAL_BIT) | // R06 R11
                    ({31'h0, inhibit} << `MPF_RS_INHIBIT_BIT); // R11

   mpf_pfc_rx
   #(
      .NPRIO         (NPRIO),
      .QW            (QW),
      .QUANTA_CYCLES (QUANTA_CYCLES)
   )
   u_pfc
   (
      .clk         (CLOCK),
      .nrst        (NRST),
      .frame_valid (RX_PFC_VALID),
      .prio_vec    (RX_PFC_PRIO),
      .quanta      (RX_PFC_QUANTA),
      .prio_en     (FLOW_CTRL_CFG[`MPF_FC_RX_PRIO_LSB +: NPRIO]),
      .global_en   (FLOW_CTRL_CFG[`MPF_FC_RX_PFC_BIT]),
      .pause_out   (pause_out),
      .taken       (pfc_taken),
      .passed      (pfc_passed)
   );

   assign RX_PRIO7_PAUSE_OUT = pause_out[7];
   assign RX_PRIO6_PAUSE_OUT = pause_out[6];
   assign RX_PRIO5_PAUSE_OUT = pause_out[5];
   assign RX_PRIO4_PAUSE_OUT = pause_out[4];
   assign RX_PRIO3_PAUSE_OUT = pause_out[3];
   assign RX_PRIO2_PAUSE_OUT = pause_out[2];
   assign RX_PRIO1_PAUSE_OUT = pause_out[1];
   assign RX_PRIO0_PAUSE_OUT = pause_out[0];

   mpf_rs_fault
   #(
      .SEQ_COUNT  (`MPF_FAULT_SEQ_COUNT),
      .CLEAR_COLS (`MPF_FAULT_CLEAR_COLS)
   )
   u_rs
   (
      .clk          (CLOCK),
      .nrst         (NRST),
      .rxd          (RXD),
      .rxc          (RXC),
      .txd_in       (TXD_IN),
      .txc_in       (TXC_IN),
      .inhibit      (inhibit),
      .txd_out      (TXD_OUT),
      .txc_out      (TXC_OUT),
      .local_fault  (local_fault),
      .remote_fault (remote_fault)
   );

   // Events: rising edges of either fault and each processed pause frame.
   assign events = {pfc_taken, remote_fault & ~remote_d, local_fault & ~local_d};

   always @*
   begin
      next_prdata = 32'h0000_0000;
      next_slverr = 1'b0;
      if (hit_fc)
         next_prdata = FLOW_CTRL_CFG;
      else if (hit_rs)
         next_prdata = rs_word;
      else if (hit_st)
         next_prdata = {{(32-`MPF_INT_W){1'b0}}, int_status};
      else if (hit_en)
         next_prdata = {{(32-`MPF_INT_W){1'b0}}, int_enable};
      else if (!hit_clr)
         next_slverr = 1'b1;
   end

   // A new event wins over a clear written in the same cycle.
   always @*
   begin
      next_status = int_status;
      if (wr && hit_clr)
         next_status = int_status & ~PWDATA[`MPF_INT_W-1:0];
      next_status = next_status | events;
   end

   // Each access phase takes two cycles: PREADY rises in the second.
   always @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY  <= access;
         PSLVERR <= access & next_slverr;
         if (access && !PWRITE)
            PRDATA <= next_prdata;
         else if (access)
            PRDATA <= 32'h0000_0000;
      end
   end

   always @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         FLOW_CTRL_CFG <= FC_RESET; // R04
         inhibit       <= 1'b0; // R07
         int_enable    <= {`MPF_INT_W{1'b0}};
      end
      else if (wr)
      begin
         if (hit_fc)
            FLOW_CTRL_CFG <= merge(FLOW_CTRL_CFG, PWDATA, PSTRB, FC_MASK); // R04
         if (hit_rs)
            inhibit <= |(merge(rs_word, PWDATA, PSTRB, RS_MASK) & RS_MASK); // R07 R09 R11
         if (hit_en && PSTRB[0])
            int_enable <= PWDATA[`MPF_INT_W-1:0];
      end
   end

   always @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         int_status  <= {`MPF_INT_W{1'b0}};
         local_d     <= 1'b0;
         remote_d    <= 1'b0;
         IRQ         <= 1'b0;
         RX_PFC_PASS <= 1'b0;
      end
      else
      begin
         int_status  <= next_status;
         local_d     <= local_fault;
         remote_d    <= remote_fault;
         IRQ         <= |(next_status & int_enable);
         RX_PFC_PASS <= pfc_passed; // R10
      end
   end
endmodule // mpf_top

// [verification/mpf_top_sva.sv]
// Port checker of the priority pause gate and fault handling block.
// Assumes it is bound to every instance of mpf_top.
`timescale 1ns/100ps
module mpf_top_sva
#(
   parameter HAS_PFC = 1,
   parameter NPRIO   = 8,
   parameter QW      = 16
)
(
   input wire                CLOCK,              // Core clock.
   input wire                NRST,               // Reset, active low.
   input wire                PSEL,               // APB select.
   input wire                PENABLE,            // APB access phase.
   input wire [7:0]          PADDR,              // APB address.
   input wire                PREADY,             // APB ready.
   input wire                PSLVERR,            // APB error.
   input wire                RX_PFC_VALID,       // Frame pulse.
   input wire [NPRIO-1:0]    RX_PFC_PRIO,        // Priorities with quanta.
   input wire [NPRIO*QW-1:0] RX_PFC_QUANTA,      // Quanta.
   input wire                RX_PFC_PASS,        // Frame passed on.
   input wire                RX_PRIO7_PAUSE_OUT, // Priority 7 pause.
   input wire                RX_PRIO0_PAUSE_OUT, // Priority 0 pause.
   input wire [31:0]         FLOW_CTRL_CFG       // Flow control word.
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   chk_ready_follows: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("ready missing after access phase");
   chk_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   chk_err_unmapped: assert property (PREADY && PADDR > 8'h10 |-> PSLVERR)
      else $error("no error on unmapped address");
   chk_prio7_gated: assert property (!FLOW_CTRL_CFG[7] [*2] |-> !RX_PRIO7_PAUSE_OUT)
      else $error("priority 7 pause while disabled");
   chk_prio0_gated: assert property (!FLOW_CTRL_CFG[0] [*2] |-> !RX_PRIO0_PAUSE_OUT)
      else $error("priority 0 pause while disabled");
   chk_global_off: assert property (!FLOW_CTRL_CFG[25] [*2] |->
      !(RX_PRIO7_PAUSE_OUT || RX_PRIO0_PAUSE_OUT))
      else $error("pause while global enable clear");
   chk_prio7_load: assert property (RX_PFC_VALID && FLOW_CTRL_CFG[25] && FLOW_CTRL_CFG[7]
      && RX_PFC_PRIO[7] && RX_PFC_QUANTA[NPRIO*QW-1 -: QW] != 0 |=> RX_PRIO7_PAUSE_OUT)
      else $error("priority 7 frame not processed");
   chk_pass_delay: assert property (RX_PFC_VALID && !FLOW_CTRL_CFG[25] |-> ##2 RX_PFC_PASS)
      else $error("ignored frame not passed on");
   chk_pass_cause: assert property (RX_PFC_PASS |-> $past(RX_PFC_VALID, 2))
      else $error("pass pulse without frame");
   chk_reset_enables: assert property ($rose(NRST) |->
      FLOW_CTRL_CFG[7:0] == (HAS_PFC ? 8'hFF : 8'h00))
      else $error("wrong priority enable reset value");
endmodule // mpf_top_sva
bind mpf_top mpf_top_sva #(.HAS_PFC(HAS_PFC), .NPRIO(NPRIO), .QW(QW)) u_sva
(
   .CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_PFC_VALID(RX_PFC_VALID),
   .RX_PFC_PRIO(RX_PFC_PRIO), .RX_PFC_QUANTA(RX_PFC_QUANTA), .RX_PFC_PASS(RX_PFC_PASS),
   .RX_PRIO7_PAUSE_OUT(RX_PRIO7_PAUSE_OUT), .RX_PRIO0_PAUSE_OUT(RX_PRIO0_PAUSE_OUT),
   .FLOW_CTRL_CFG(FLOW_CTRL_CFG)
);

// [verification/mpf_pcs_model.sv]
// Receive side of the PCS: sends idle, local fault or remote fault words.
// Assumes the bench changes the mode on the core clock.
`timescale 1ns/100ps
module mpf_pcs_model
(
   input  wire       clk,  // Core clock.
   input  wire [1:0] mode, // Idle, local fault or remote fault.
   output reg [63:0] rxd,  // Receive data.
   output reg [7:0]  rxc   // Receive control.
);
   initial
   begin
      rxd = 64'h0707070707070707;
      rxc = 8'hFF;
   end
   always @(posedge clk)
   begin
      rxd <= mode == 2'h1 ? 64'h0100009C0100009C :
             mode == 2'h2 ? 64'h0200009C0200009C : 64'h0707070707070707;
      rxc <= mode == 2'h0 ? 8'hFF : 8'h11;
   end
endmodule // mpf_pcs_model

// [verification/mpf_top_bench.sv]
// Self-checking bench of mpf_top: APB master, pause frames, fault words.
// Assumes the PCS model and the checker are compiled before it.
`timescale 1ns/100ps
module mpf_top_bench;
   reg          CLOCK = 0;
   reg          NRST = 0;
   reg          PSEL = 0;
   reg          PENABLE = 0;
   reg          PWRITE = 0;
   reg [7:0]    PADDR = 8'h00;
   reg [31:0]   PWDATA = 32'h0;
   reg          RX_PFC_VALID = 0;
   reg [7:0]    RX_PFC_PRIO = 8'h00;
   reg [127:0]  RX_PFC_QUANTA = 128'h0;
   reg [63:0]   TXD_IN = 64'h0;
   reg [7:0]    TXC_IN = 8'h00;
   reg [1:0]    mode = 2'h0;
   reg [31:0]   rd, lfsr;
   reg [127:0]  q;
   reg [7:0]    en, qnz, p;
   reg          err;
   integer      fail_count, n_checks, i, j, k;
   wire [31:0]  PRDATA, FLOW_CTRL_CFG;
   wire         PREADY, PSLVERR, RX_PFC_PASS, IRQ;
   wire [7:0]   pause, RXC, TXC_OUT;
   wire [63:0]  RXD, TXD_OUT;
   mpf_top DUT
   (
      .CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hF), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .RX_PFC_VALID(RX_PFC_VALID), .RX_PFC_PRIO(RX_PFC_PRIO),
      .RX_PFC_QUANTA(RX_PFC_QUANTA), .RX_PFC_PASS(RX_PFC_PASS),
      .RX_PRIO7_PAUSE_OUT(pause[7]), .RX_PRIO6_PAUSE_OUT(pause[6]),
      .RX_PRIO5_PAUSE_OUT(pause[5]), .RX_PRIO4_PAUSE_OUT(pause[4]),
      .RX_PRIO3_PAUSE_OUT(pause[3]), .RX_PRIO2_PAUSE_OUT(pause[2]),
      .RX_PRIO1_PAUSE_OUT(pause[1]), .RX_PRIO0_PAUSE_OUT(pause[0]), .RXD(RXD), .RXC(RXC),
      .TXD_IN(TXD_IN), .TXC_IN(TXC_IN), .TXD_OUT(TXD_OUT), .TXC_OUT(TXC_OUT),
      .FLOW_CTRL_CFG(FLOW_CTRL_CFG), .IRQ(IRQ)
   );
   mpf_pcs_model u_pcs (.clk(CLOCK), .mode(mode), .rxd(RXD), .rxc(RXC));
   always #4 CLOCK = ~CLOCK;
   function [31:0] nxt(input [31:0] s);
      nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input [63:0] seen, input [63:0] exp);
   begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task wrap_up;
   begin
      if (fail_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   // One APB transfer; it leaves one idle cycle so no signal is set twice at an edge.
   task apb(input w, input [7:0] a, input [31:0] d);
   begin
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      k = 0;
      @(posedge CLOCK);
      while (PREADY !== 1'b1 && k < 16)
      begin
         @(posedge CLOCK);
         k = k + 1;
      end
      if (PREADY !== 1'b1)
      begin
         fail_count = fail_count + 1;
         wrap_up;
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
   end
   endtask
   task rd_chk(input [7:0] a, input [31:0] exp);
   begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   end
   endtask
   task frame(input [7:0] pr, input [127:0] qu);
   begin
      RX_PFC_VALID <= 1'b1;
      RX_PFC_PRIO <= pr;
      RX_PFC_QUANTA <= qu;
      @(posedge CLOCK);
      RX_PFC_VALID <= 1'b0;
      #1;
   end
   endtask
   initial
   begin
      fail_count = 0;
      n_checks = 0;
      lfsr = 32'h00010D94;
      repeat (2) @(posedge CLOCK);
      NRST <= 1'b1;
      @(posedge CLOCK);
      chk(FLOW_CTRL_CFG, 32'h6010FFFF);
      rd_chk(8'h00, 32'h6010FFFF);
      rd_chk(8'h04, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      // Global receive enable is clear after reset, so the frame is passed on.
      frame(8'hFF, {8{16'h0005}});
      @(posedge CLOCK);
      #1;
      chk(RX_PFC_PASS, 1'b1);
      chk(pause, 8'h00);
      @(posedge CLOCK);
      rd_chk(8'h08, 32'h0);
      for (i = 0; i < 8; i = i + 1)
      begin
         lfsr = nxt(nxt(lfsr));
         en = i == 0 ? 8'h00 : i == 1 ? 8'hFF : lfsr[7:0];
         p = i < 2 ? 8'hFF : lfsr[15:8];
         apb(1'b1, 8'h00, 32'h62100000 | en);
         lfsr = nxt(lfsr);
         for (j = 0; j < 8; j = j + 1)
         begin
            q[16*j +: 16] = {12'h000, lfsr[4*j +: 4]};
            qnz[j] = lfsr[4*j +: 4] != 4'h0;
         end
         frame(p, q);
         chk(pause, en & qnz & p);
         @(posedge CLOCK);
         frame(8'hFF, 128'h0);
         chk(pause, 8'h00);
         @(posedge CLOCK);
      end
      chk(IRQ, 1'b0);
      rd_chk(8'h08, 32'h4);
      apb(1'b1, 8'h10, 32'h4);
      repeat (2) @(posedge CLOCK);
      chk(IRQ, 1'b1);
      apb(1'b1, 8'h0C, 32'h4);
      repeat (2) @(posedge CLOCK);
      chk(IRQ, 1'b0);
      rd_chk(8'h08, 32'h0);
      apb(1'b1, 8'h10, 32'h0);
      TXD_IN <= {lfsr, nxt(lfsr)};
      mode <= 2'h1;
      repeat (8) @(posedge CLOCK);
      #1;
      chk(TXD_OUT, 64'h0200009C0200009C);
      chk(TXC_OUT, 8'h11);
      @(posedge CLOCK);
      rd_chk(8'h04, 32'h10000000);
      mode <= 2'h0;
      repeat (70) @(posedge CLOCK);
      rd_chk(8'h04, 32'h0);
      mode <= 2'h2;
      repeat (8) @(posedge CLOCK);
      #1;
      chk(TXD_OUT, 64'h0707070707070707);
      chk(TXC_OUT, 8'hFF);
      @(posedge CLOCK);
      rd_chk(8'h04, 32'h20000000);
      apb(1'b1, 8'h04, 32'hFFFFFFFF);
      repeat (2) @(posedge CLOCK);
      #1;
      chk(TXD_OUT, TXD_IN);
      chk(TXC_OUT, TXC_IN);
      @(posedge CLOCK);
      rd_chk(8'h04, 32'h28000000);
      wrap_up;
   end
endmodule // mpf_top_bench
